// ### hw/fpc_pkg.sv
// Package for the front panel power and channel control block
// Summary of operation
// - The unit switches on only while the power button is held and lights the display once power-up takes effect.
// - While running, a power press switches the unit off only after being held until the display blanks.
// - Shutdown needs the power button held for a one-second delay so a brief press is ignored.
// - While running with the display dark, a channel press only lights the display and shows the selection unchanged.
// - A channel press while running with the display lit advances the selection to the next channel or setting.
// - The selection includes an automatic setting shown as lower-case b that puts the unit in automatic mode.
// - The display stays lit only a limited time after the last press of either button, then blanks.
// - The channel number runs from 0 through 15 and every value is offered.
// - Two-digit channels flash a 1 then the units digit, alternating while the display is lit.
// - The decimal point is lit while the automatic setting b is shown and off while a manual channel is shown.
package fpc_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned OFF_DELAY_MS    = 1000;
  localparam int unsigned OFF_DELAY_CYC   = (OFF_DELAY_MS * (CLK_HZ / 1000));
  localparam int unsigned DEBOUNCE_CYC    = 100_000;
  localparam int unsigned DISP_ON_CYC     = 500_000_000;
  localparam int unsigned FLASH_CYC       = 50_000_000;
  localparam int unsigned CNT_W           = 32;
  localparam logic [4:0]  SEL_AUTO        = 5'h10;
  localparam logic [4:0]  SEL_RESET       = 5'h10;
  localparam logic [6:0]  SEG_B           = 7'h7c;
  localparam logic [6:0]  SEG_BLANK       = 7'h00;

  typedef enum logic [2:0] {
    FPC_OFF     = 3'b001,
    FPC_RUN     = 3'b010,
    FPC_SHUT    = 3'b100
  } fpc_state_e;

  // Segment order g f e d c b a
  function automatic logic [6:0] fpc_digit(input logic [3:0] d);
    case (d)
      4'h0: fpc_digit = 7'h3f;
      4'h1: fpc_digit = 7'h06;
      4'h2: fpc_digit = 7'h5b;
      4'h3: fpc_digit = 7'h4f;
      4'h4: fpc_digit = 7'h66;
      4'h5: fpc_digit = 7'h6d;
      4'h6: fpc_digit = 7'h7d;
      4'h7: fpc_digit = 7'h07;
      4'h8: fpc_digit = 7'h7f;
      4'h9: fpc_digit = 7'h6f;
      default: fpc_digit = 7'h00;
    endcase
  endfunction : fpc_digit
endpackage : fpc_pkg

// ### hw/fpc_panel.sv
// Front panel power, channel selection and seven-segment display control
`timescale 1ns/1ns
module fpc_panel
  import fpc_pkg::*;
#(
  parameter int unsigned OFF_CYC  = OFF_DELAY_CYC,
  parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
  parameter int unsigned DISP_CYC = DISP_ON_CYC,
  parameter int unsigned FL_CYC   = FLASH_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Buttons, high while pressed
  input  wire logic       pwr_btn,
  input  wire logic       chan_btn,
  // Power control
  output logic            power_on,
  // Display, segments g..a and decimal point
  output logic [6:0]      seg,
  output logic            seg_dp,
  // Choice handed to the radio core
  output logic [3:0]      chan_num,
  output logic            auto_mode
);
  logic [2:0]       pwr_sync_q, chan_sync_q;
  logic             pwr_raw, chan_raw;
  logic             pwr_db_q, chan_db_q, chan_db_prev_q, pwr_db_prev_q;
  logic [CNT_W-1:0] pwr_deb_q, chan_deb_q;
  fpc_state_e       state_q, state_d;
  logic [CNT_W-1:0] off_cnt_q, disp_cnt_q, flash_cnt_q;
  logic [CNT_W-1:0] shut_len_q;
  logic             disp_on_q, phase_q;
  logic [4:0]       sel_q;
  logic [6:0]       seg_q;
  logic             dp_q;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_sync_q  <= 3'h0;
      chan_sync_q <= 3'h0;
    end else begin
      pwr_sync_q  <= {pwr_sync_q[1:0], pwr_btn};
      chan_sync_q <= {chan_sync_q[1:0], chan_btn};
    end
  end
  assign pwr_raw  = pwr_sync_q[2] & pwr_sync_q[1];
  assign chan_raw = chan_sync_q[2] & chan_sync_q[1];
  wire pwr_agree  = pwr_sync_q[2] == pwr_sync_q[1];
  wire chan_agree = chan_sync_q[2] == chan_sync_q[1];

  // Debounce: level must stay stable DEB_CYC cycles before it is taken
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_deb_q  <= '0;
      chan_deb_q <= '0;
      pwr_db_q   <= 1'b0;
      chan_db_q  <= 1'b0;
    end else begin
      if (!pwr_agree || pwr_raw == pwr_db_q) pwr_deb_q <= '0;
      else if (pwr_deb_q >= CNT_W'(DEB_CYC - 1)) begin
        pwr_deb_q <= '0;
        pwr_db_q  <= pwr_raw;
      end else pwr_deb_q <= pwr_deb_q + 1'b1;
      if (!chan_agree || chan_raw == chan_db_q) chan_deb_q <= '0;
      else if (chan_deb_q >= CNT_W'(DEB_CYC - 1)) begin
        chan_deb_q <= '0;
        chan_db_q  <= chan_raw;
      end else chan_deb_q <= chan_deb_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_db_prev_q  <= 1'b0;
      chan_db_prev_q <= 1'b0;
    end else begin
      pwr_db_prev_q  <= pwr_db_q;
      chan_db_prev_q <= chan_db_q;
    end
  end
  wire pwr_press  = pwr_db_q & ~pwr_db_prev_q;
  wire chan_press = chan_db_q & ~chan_db_prev_q;
  wire running    = (state_q == FPC_RUN);
  wire off_done   = (off_cnt_q >= CNT_W'(OFF_CYC - 1));
  wire any_press  = running & (pwr_press | chan_press);

  // Power state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      // A fresh press is needed, so the hold that ended a shutdown cannot power up again
      FPC_OFF:  if (pwr_press) state_d = FPC_RUN;
      // Release after power-up waits here so the same hold cannot also turn off
      FPC_RUN:  if (pwr_press) state_d = FPC_SHUT;
      FPC_SHUT: begin
        if (!pwr_db_q) state_d = FPC_RUN;
        else if (off_done) state_d = FPC_OFF;
      end
      default:  state_d = FPC_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) state_q <= FPC_OFF;
    else state_q <= state_d;
  end

  // Hold timer for shutdown
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) off_cnt_q <= '0;
    else if (state_q != FPC_SHUT) off_cnt_q <= '0;
    else if (!off_done) off_cnt_q <= off_cnt_q + 1'b1;
  end

  // Display timeout; also lit at power-up. Blanks while a shutdown hold completes.
  wire power_up = (state_q == FPC_OFF) & (state_d == FPC_RUN);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      disp_cnt_q <= '0;
      disp_on_q  <= 1'b0;
    end else if (power_up || any_press) begin
      disp_cnt_q <= '0;
      disp_on_q  <= 1'b1;
    end else if (state_q == FPC_OFF || (state_q == FPC_SHUT && off_done)) begin
      disp_on_q  <= 1'b0;
    end else if (disp_on_q) begin
      if (disp_cnt_q >= CNT_W'(DISP_CYC - 1)) disp_on_q <= 1'b0;
      else disp_cnt_q <= disp_cnt_q + 1'b1;
    end
  end

  // Selection: 0..15 then automatic, then wrap
  wire [4:0] sel_next = (sel_q == SEL_AUTO) ? 5'h00 : sel_q + 5'h01;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) sel_q <= SEL_RESET;
    else if (running && chan_press && disp_on_q) sel_q <= sel_next;
  end

  // Flash phase: 0 shows the leading 1, 1 shows the units digit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flash_cnt_q <= '0;
      phase_q     <= 1'b0;
    end else if (any_press || !disp_on_q) begin
      flash_cnt_q <= '0;
      phase_q     <= 1'b0;
    end else if (flash_cnt_q >= CNT_W'(FL_CYC - 1)) begin
      flash_cnt_q <= '0;
      phase_q     <= ~phase_q;
    end else flash_cnt_q <= flash_cnt_q + 1'b1;
  end

  wire        is_auto  = (sel_q == SEL_AUTO);
  wire        two_dig  = ~is_auto & (sel_q[3:0] >= 4'ha);
  wire [3:0]  units    = two_dig ? 4'(sel_q[3:0] - 4'ha) : sel_q[3:0];
  wire [3:0]  shown    = (two_dig && !phase_q) ? 4'h1 : units;
  wire [6:0]  seg_d    = !disp_on_q ? SEG_BLANK : is_auto ? SEG_B : fpc_digit(shown);
  // The automatic choice has no fixed channel, so dp marks the b setting
  wire        dp_d     = disp_on_q & is_auto;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      seg_q <= SEG_BLANK;
      dp_q  <= 1'b0;
    end else begin
      seg_q <= seg_d;
      dp_q  <= dp_d;
    end
  end

  assign power_on  = ~(state_q == FPC_OFF);
  assign seg       = seg_q;
  assign seg_dp    = dp_q;
  assign chan_num  = sel_q[3:0];
  assign auto_mode = is_auto;

  // Separate count of cycles spent holding for shutdown, kept apart from the timer it checks
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) shut_len_q <= '0;
    else if (state_q != FPC_SHUT) shut_len_q <= '0;
    else if (shut_len_q < CNT_W'(OFF_CYC)) shut_len_q <= shut_len_q + 1'b1;
  end

  a_off_needs_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == FPC_SHUT) && (state_d == FPC_OFF) |-> off_cnt_q >= CNT_W'(OFF_CYC - 1))
    else $error("shutdown before hold delay");
  a_on_needs_press: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(power_on) |-> $past(pwr_db_q))
    else $error("power on without held button");
  a_dark_no_change: assert property (@(posedge sys_clk) disable iff (!resetn)
    chan_press && !disp_on_q |=> $stable(sel_q))
    else $error("selection changed while dark");
  a_lit_advances: assert property (@(posedge sys_clk) disable iff (!resetn)
    running && chan_press && disp_on_q |=> sel_q == (($past(sel_q) == SEL_AUTO) ? 5'h00 : 5'($past(sel_q) + 5'h01)))
    else $error("selection did not advance");
  a_sel_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    sel_q <= SEL_AUTO)
    else $error("selection out of range");
  a_auto_wraps: assert property (@(posedge sys_clk) disable iff (!resetn)
    running && chan_press && disp_on_q && is_auto |=> sel_q == 5'h00)
    else $error("automatic setting did not wrap");
  a_dp_auto: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 seg_dp == $past(disp_on_q && is_auto))
    else $error("decimal point mismatch");
  a_dark_blank: assert property (@(posedge sys_clk) disable iff (!resetn)
    !disp_on_q |=> seg == SEG_BLANK && !seg_dp)
    else $error("display lit while dark");
  a_press_lights: assert property (@(posedge sys_clk) disable iff (!resetn)
    any_press |=> disp_on_q && disp_cnt_q == '0)
    else $error("press did not restart display");
  a_off_after_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(power_on) |-> shut_len_q >= CNT_W'(OFF_CYC))
    else $error("power off before full hold");
  a_off_blanks: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(power_on) |=> seg == SEG_BLANK && !seg_dp)
    else $error("display lit after power off");
  a_up_lights: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(power_on) |-> disp_on_q)
    else $error("display dark at power up");
  a_off_ignores_chan: assert property (@(posedge sys_clk) disable iff (!resetn)
    !running && chan_press |=> $stable(sel_q))
    else $error("selection changed while not running");
  a_flash_lead: assert property (@(posedge sys_clk) disable iff (!resetn)
    disp_on_q && two_dig && !phase_q |=> seg == 7'h06)
    else $error("leading digit not shown first");
  a_flash_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
    any_press |=> !phase_q && flash_cnt_q == '0)
    else $error("press did not restart flash");
endmodule : fpc_panel

// ### verif/fpc_operator.sv
// Operator model that presses the panel buttons
`timescale 1ns/1ns
module fpc_operator (
  // Clock
  input  wire logic sys_clk,
  // Buttons, high while pressed
  output logic      pwr_btn,
  output logic      chan_btn
);
  initial begin
    pwr_btn  = 1'b0;
    chan_btn = 1'b0;
  end
  // Levels change on the falling edge only, away from the sampling edge
  task automatic press(input logic is_pwr, input int hold);
    logic bounce;
    bounce = 1'($urandom);
    @(negedge sys_clk);
    // Contact bounce: one random cycle, too short to pass the synchroniser on its own
    if (is_pwr) pwr_btn = bounce;
    else chan_btn = bounce;
    @(negedge sys_clk);
    if (is_pwr) pwr_btn = 1'b1;
    else chan_btn = 1'b1;
    repeat (hold) @(negedge sys_clk);
    pwr_btn  = 1'b0;
    chan_btn = 1'b0;
  endtask : press
endmodule : fpc_operator

// ### verif/tb_top.sv
// Self-checking testbench for the front panel block
`timescale 1ns/1ns
module tb_top;
  import fpc_pkg::*;
  logic       sys_clk;
  logic       resetn;
  wire logic  pwr_btn;
  wire logic  chan_btn;
  logic       power_on;
  logic [6:0] seg;
  logic       seg_dp;
  logic [3:0] chan_num;
  logic       auto_mode;
  logic [5:0] exp_q[$];
  logic [5:0] prev;
  logic [5:0] cur;
  logic [6:0] dig[10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  int         n_errors;
  int         check_count;
  // Short counts keep the run brief; all waits below derive from them
  fpc_panel #(.OFF_CYC(20), .DEB_CYC(2), .DISP_CYC(200), .FL_CYC(10)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .pwr_btn(pwr_btn), .chan_btn(chan_btn), .power_on(power_on),
    .seg(seg), .seg_dp(seg_dp), .chan_num(chan_num), .auto_mode(auto_mode));
  fpc_operator op (.sys_clk(sys_clk), .pwr_btn(pwr_btn), .chan_btn(chan_btn));
  assign cur = {power_on, auto_mode, chan_num};
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  // Bounded wait; a miss ends the run
  task automatic wait_seg(input logic [6:0] e, input int lim);
    int k;
    k = 0;
    while (seg !== e && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    cmp("seg", 8'(e), 8'(seg));
    if (seg !== e) end_sim();
  endtask : wait_seg
  // Any change of the choice or power state must match the oldest note
  always @(negedge sys_clk) begin
    if (resetn === 1'b1 && cur !== prev) begin
      if (exp_q.size() == 0) cmp("choice", 8'(prev), 8'(cur));
      else cmp("choice", 8'(exp_q.pop_front()), 8'(cur));
    end
    prev <= cur;
  end
  initial begin
    resetn      = 1'b0;
    n_errors    = 0;
    check_count = 0;
    void'($urandom(32'hf06bab64));
    repeat (2) @(negedge sys_clk);
    cmp("reset", 8'h10, 8'(cur));
    resetn = 1'b1;
    op.press(1'b1, 1);
    repeat (10) @(negedge sys_clk);
    cmp("power_on", 8'h0, 8'(power_on));
    exp_q.push_back(6'h30);
    op.press(1'b1, 15);
    cmp("power_on", 8'h1, 8'(power_on));
    wait_seg(SEG_B, 4);
    cmp("seg_dp", 8'h1, 8'(seg_dp));
    repeat (150) @(negedge sys_clk);
    cmp("lit", 8'h1, 8'(seg !== SEG_BLANK));
    wait_seg(SEG_BLANK, 100);
    op.press(1'b0, 10);
    wait_seg(SEG_B, 4);
    repeat (12) @(negedge sys_clk);
    for (int i = 0; i < 17; i++) begin
      exp_q.push_back(i < 16 ? {2'b10, 4'(i)} : 6'h30);
      op.press(1'b0, 8 + ($urandom % 4));
      if (i < 10) begin
        wait_seg(dig[i], 4);
      end else if (i < 16) begin
        wait_seg(dig[1], 4);
        wait_seg(dig[i-10], 12);
        wait_seg(dig[1], 12);
      end else begin
        wait_seg(SEG_B, 4);
      end
      cmp("seg_dp", 8'(i == 16), 8'(seg_dp));
      repeat (12) @(negedge sys_clk);
    end
    op.press(1'b1, 10);
    repeat (30) @(negedge sys_clk);
    cmp("power_on", 8'h1, 8'(power_on));
    exp_q.push_back(6'h10);
    op.press(1'b1, 40);
    wait_seg(SEG_BLANK, 4);
    op.press(1'b0, 10);
    repeat (10) @(negedge sys_clk);
    cmp("seg", 8'(SEG_BLANK), 8'(seg));
    cmp("queue", 8'h0, 8'(exp_q.size()));
    end_sim();
  end
endmodule : tb_top
